// ===== ulbrt_pkg.sv
// ulbrt_pkg: register indices, field positions, reset values, types
// for the serial transceiver with sync-break support.
// assumes a 32-bit AHB-Lite register bus, one word per register.
package ulbrt_pkg;
  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_CTRL   = 30'h0FFFFA00;
  localparam logic [29:0] IDX_OPT0   = 30'h0FFFFA03;
  localparam logic [29:0] IDX_STS    = 30'h0FFFFA04;
  localparam logic [29:0] IDX_RX     = 30'h0FFFFA06;
  localparam logic [29:0] IDX_TX     = 30'h0FFFFA08;
  localparam logic [29:0] IDX_OPT1   = 30'h0FFFFA0A;
  localparam logic [29:0] IDX_RXST   = 30'h0FFFFA0B;
  localparam logic [29:0] IDX_BAUD   = 30'h0FFFFA0C;
  localparam logic [29:0] IDX_FILT   = 30'h0FFFFA0D;
  // option register 0 fields
  localparam int OPT0_BRP = 7;
  localparam int OPT0_BRT = 6;
  localparam int OPT0_BTT = 5;
  localparam int OPT0_BLS = 2;
  localparam int OPT0_INV = 1;
  // status register: transfer busy bit, error flags in bits 2..0
  localparam int STS_BUSY = 7;
  localparam int STS_PE   = 2;
  localparam int STS_FE   = 1;
  localparam int STS_OVE  = 0;
  // reset and initial values
  localparam logic [8:0]  RXBUF_RST = 9'h1FF;
  localparam logic [8:0]  TXBUF_RST = 9'h1FF;
  localparam logic [8:0]  RXSH_INIT = 9'h0FF;
  localparam logic [2:0]  BLS_RST   = 3'h5;
  localparam logic [7:0]  FILT_RST  = 8'h08;
  localparam logic [15:0] BAUD_RST  = 16'h001B;
  // timing: sixteen baud ticks per bit, break judged at 11 bit times
  localparam logic [3:0]  BIT_LAST  = 4'hF;
  localparam logic [4:0]  BRK_MIN   = 5'h0B;
  // parity select encodings
  localparam logic [1:0]  PAR_NONE  = 2'h0;
  localparam logic [1:0]  PAR_ZERO  = 2'h1;
  localparam logic [1:0]  PAR_ODD   = 2'h2;
  localparam logic [1:0]  PAR_EVEN  = 2'h3;

  typedef struct packed {
    logic [1:0] parity;
    logic       msb_first;
    logic       stop2;
    logic       char8;
    logic       tx_en;
    logic       rx_en;
    logic       unit_power;
  } ulbrt_ctrl_s;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
    RX_PAR = 3'h2, RX_STOP = 3'h6, RX_BRK = 3'h7
  } ulbrt_rx_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
    TX_PAR = 3'h2, TX_STOP = 3'h6, TX_BRK = 3'h4
  } ulbrt_tx_e;
endpackage

// ===== ulbrt_core.sv
// ulbrt_core: serial transceiver channel with sync-break send/receive.
// assumes an AHB-Lite master on mclk and a line transceiver on the pins.
//
// How it works
// R1 - active flag set on confirmed start, cleared at first stop or when off
// R2 - with two stop bits, active flag clears with the done pulse
// R3 - 9-bit receive buffer loaded from shift register at frame end
// R4 - ninth bit lands in bit 8 when extension is on
// R5 - 7-bit data: LSB-first in 6..0, MSB-first in 7..1
// R6 - overrun frames never overwrite the receive buffer
// R7 - receive buffer read-only, 1FF at reset and while powered down
// R8 - transmit buffer read/write, resets to 1FF
// R9 - done pulse only for error-free frames or valid breaks with reception enabled
// R10 - error pulse for parity, framing or overrun, flags record cause
// R11 - each frame gives exactly one of done or error pulse
// R12 - ready pulse when buffer moves to the shift register
// R13 - full duplex; 7/8/9 bits, parity options, one or two stops
// R14 - MSB or LSB first, optional inverted serial output
// R15 - ninth bit only with parity none, in place of parity
// R16 - break sent in hardware, low for selected bit times
// R17 - ready pulse also at start of each break
// R18 - received break of 11+ bit times is valid, gives done pulse
// R19 - short break: no pulse, stay in break receive mode
// R20 - valid break loads nothing and checks no errors
// R21 - software sends wakeup as 80 hex and times field gaps
// R22 - break length field spans 13 to 20, reset selects 13
// R23 - break trigger clears itself when the break ends
// R24 - start bit: falling edge, then re-sample after filter count
// R25 - error flags cleared only by writing zero or by turning reception off
// R26 - all bit timing from a baud tick on the peripheral clock
`timescale 1ns/1ns
`default_nettype none
module ulbrt_core
  import ulbrt_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV_RST = BAUD_RST
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        serial_in,
  output var  logic        serial_out,
  output var  logic        rx_done_irq,
  output var  logic        rx_error_irq,
  output var  logic        tx_ready_irq
);
  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [4:0] brk_bits(input logic [2:0] sel);
    case (sel)
      3'h5: brk_bits = 5'h0D;
      3'h6: brk_bits = 5'h0E;
      3'h7: brk_bits = 5'h0F;
      3'h2: brk_bits = 5'h10;
      3'h1: brk_bits = 5'h11;
      3'h0: brk_bits = 5'h12;
      3'h3: brk_bits = 5'h13;
      default: brk_bits = 5'h14;
    endcase
  endfunction

  function automatic logic [8:0] mask_n(input logic [8:0] d, input logic [3:0] n);
    mask_n = d & ((9'h001 << n) - 9'h001);
  endfunction

  function automatic logic [8:0] rev_n(input logic [8:0] d, input logic [3:0] n);
    rev_n = 9'h000;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        rev_n[i] = d[int'(n) - 1 - i];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state
  ulbrt_ctrl_s ctrl;
  ulbrt_rx_e   rx_st;
  ulbrt_tx_e   tx_st;
  logic [2:0]  brk_len_sel;
  logic        tx_invert, break_tx_trigger, break_rx_pending, ninth_bit_enable;
  logic [2:0]  err_flags;
  logic [8:0]  rx_buf, tx_buf, rx_sh, tx_sh;
  logic        rx_unread, tx_pending, rx_active_flag, rx_perr, tx_pbit, tx_line;
  logic [15:0] baud_div, baud_cnt;
  logic [7:0]  start_filter_count, rx_cnt;
  logic [3:0]  rx_bits, tx_cnt;
  logic [4:0]  brk_len, tx_bits;
  logic        rx_s1, rx_s2, rx_s3, rx_line, rx_prev;
  logic        dp_wr;
  logic [29:0] dp_idx;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////
  // decode and shared terms
  wire       rx_on   = ctrl.unit_power & ctrl.rx_en;
  wire       tx_on   = ctrl.unit_power & ctrl.tx_en;
  wire       ebe_eff = ninth_bit_enable & ctrl.char8 & (ctrl.parity == PAR_NONE); // R15
  wire       par_on  = (ctrl.parity != PAR_NONE) & ~ebe_eff;
  wire [3:0] nchar   = ebe_eff ? 4'h9 : (ctrl.char8 ? 4'h8 : 4'h7); // R13
  wire       tick    = (baud_cnt == 16'h0000); // R26
  wire       ap      = hsel & htrans[1] & hready;
  wire       rd_rx   = ap & ~hwrite & (haddr[31:2] == IDX_RX);
  wire       wr_ctrl = dp_wr & (dp_idx == IDX_CTRL);
  wire       wr_opt0 = dp_wr & (dp_idx == IDX_OPT0);
  wire       wr_sts  = dp_wr & (dp_idx == IDX_STS);
  wire       wr_tx   = dp_wr & (dp_idx == IDX_TX);
  wire       wr_opt1 = dp_wr & (dp_idx == IDX_OPT1);
  wire       wr_baud = dp_wr & (dp_idx == IDX_BAUD);
  wire       wr_filt = dp_wr & (dp_idx == IDX_FILT);
  wire       tx_busy = tx_pending | break_tx_trigger | (tx_st != TX_IDLE);

  // receive events; a break never reaches the stop state, so it skips checks
  wire       rx_smp   = tick & (rx_cnt[3:0] == BIT_LAST);
  wire       rx_conf  = (rx_st == RX_START) & tick & (rx_cnt == start_filter_count)
                        & ~rx_line; // R24
  wire       rx_end   = (rx_st == RX_STOP) & rx_smp;
  wire [8:0] rx_data9 = ctrl.msb_first ? ((nchar == 4'h7) ? {1'b0, rx_sh[6:0], 1'b0}
                        : mask_n(rx_sh, nchar)) : mask_n(rx_sh, nchar); // R4 R5
  wire       ev_fe    = rx_end & ~rx_line;
  wire       ev_pe    = rx_end & rx_perr;
  wire       ev_ov    = rx_end & rx_unread;
  wire       rx_bad   = ev_fe | ev_pe | ev_ov;
  wire       rx_load  = rx_end & ~ev_ov; // R6
  wire       brk_end  = (rx_st == RX_BRK) & rx_smp & rx_line;
  wire       brk_ok   = brk_end & (brk_len >= BRK_MIN); // R18
  wire       brk_shrt = brk_end & (brk_len < BRK_MIN); // R19
  wire       par_calc = ^rx_data9 ^ rx_line ^ (ctrl.parity == PAR_ODD);
  wire [2:0] err_ev   = {ev_pe, ev_fe, ev_ov};

  // transmit events
  wire       tx_smp   = tick & (tx_cnt == BIT_LAST);
  wire       brk_go   = (tx_st == TX_IDLE) & tx_on & break_tx_trigger;
  wire       tx_load  = (tx_st == TX_IDLE) & tx_on & tx_pending & ~break_tx_trigger;
  wire       brk_done = (tx_st == TX_BRK) & tx_smp
                        & (tx_bits == brk_bits(brk_len_sel) - 5'h01); // R16 R22
  wire [8:0] tx_data  = mask_n(tx_buf, nchar);

  ////////////////////////////////////////////////////////////////////
  // pin synchroniser: a change is taken once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      {rx_s1, rx_s2, rx_s3} <= 3'h7;
      rx_line <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      {rx_s1, rx_s2, rx_s3} <= {serial_in, rx_s1, rx_s2};
      if (rx_s2 == rx_s3)
        rx_line <= rx_s3;
      rx_prev <= rx_line;
    end
  end

  // baud tick, sixteen per bit; held at zero while powered down
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !ctrl.unit_power)
      baud_cnt <= 16'h0000;
    else if (tick)
      baud_cnt <= baud_div - 16'h0001; // R26
    else
      baud_cnt <= baud_cnt - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, write data applied in the data phase
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dp_wr  <= 1'b0;
      dp_idx <= 30'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp  <= 1'b0;
    end
    else
    begin
      dp_wr  <= ap & hwrite;
      dp_idx <= ap ? haddr[31:2] : dp_idx;
      hrdata <= next_rdata;
      hreadyout <= 1'b1;
      hresp  <= 1'b0;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 32'h0;
    if (!ap || hwrite)
      next_rdata = 32'h0;
    else if (haddr[31:2] == IDX_CTRL)
      next_rdata = {24'h0, ctrl};
    else if (haddr[31:2] == IDX_OPT0)
      next_rdata = {24'h0, break_rx_pending, 2'h0, brk_len_sel, tx_invert, 1'b0};
    else if (haddr[31:2] == IDX_STS)
      next_rdata = {24'h0, tx_busy, 4'h0, err_flags};
    else if (haddr[31:2] == IDX_RX)
      next_rdata = {23'h0, rx_buf}; // R7
    else if (haddr[31:2] == IDX_TX)
      next_rdata = {23'h0, tx_buf};
    else if (haddr[31:2] == IDX_OPT1)
      next_rdata = {31'h0, ninth_bit_enable};
    else if (haddr[31:2] == IDX_RXST)
      next_rdata = {31'h0, rx_active_flag};
    else if (haddr[31:2] == IDX_BAUD)
      next_rdata = {16'h0, baud_div};
    else if (haddr[31:2] == IDX_FILT)
      next_rdata = {24'h0, start_filter_count};
  end

  // configuration registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl <= '0;
      brk_len_sel <= BLS_RST; // R22
      tx_invert <= 1'b0;
      ninth_bit_enable <= 1'b0;
      baud_div <= BAUD_DIV_RST;
      start_filter_count <= FILT_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= hwdata[7:0];
      if (wr_opt0)
        {brk_len_sel, tx_invert} <= hwdata[OPT0_BLS+2:OPT0_INV];
      if (wr_opt1)
        ninth_bit_enable <= hwdata[0];
      if (wr_baud)
        baud_div <= hwdata[15:0];
      if (wr_filt)
        start_filter_count <= hwdata[7:0];
    end
  end

  // break triggers: a software set beats the receive clear; transmit sets are ignored while busy
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !tx_on)
      break_tx_trigger <= 1'b0;
    else if (wr_opt0 && hwdata[OPT0_BTT] && !tx_busy)
      break_tx_trigger <= 1'b1;
    else if (brk_done)
      break_tx_trigger <= 1'b0; // R23
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n || !rx_on)
      break_rx_pending <= 1'b0;
    else if (wr_opt0 && hwdata[OPT0_BRT])
      break_rx_pending <= 1'b1;
    else if (brk_ok)
      break_rx_pending <= 1'b0; // R18
  end

  // error flags: hardware set wins, software can only write zero
  for (genvar i = 0; i < 3; i++)
  begin : g_flag
    always_ff @(posedge mclk)
    begin
      if (!rst_n || !rx_on)
        err_flags[i] <= 1'b0;
      else if (err_ev[i])
        err_flags[i] <= 1'b1; // R10
      else if (wr_sts && !hwdata[i])
        err_flags[i] <= 1'b0; // R25
    end
  end

  // buffers and their occupancy
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !ctrl.unit_power)
      rx_buf <= RXBUF_RST; // R7
    else if (rx_load)
      rx_buf <= rx_data9; // R3
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tx_buf <= TXBUF_RST; // R8
    else if (wr_tx)
      tx_buf <= hwdata[8:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n || !rx_on)
      rx_unread <= 1'b0;
    else if (rx_load)
      rx_unread <= 1'b1;
    else if (rd_rx)
      rx_unread <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n || !tx_on)
      tx_pending <= 1'b0;
    else if (wr_tx)
      tx_pending <= 1'b1;
    else if (tx_load)
      tx_pending <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // receiver
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !rx_on)
    begin
      rx_st <= RX_IDLE;
      rx_cnt <= 8'h00;
      rx_bits <= 4'h0;
      rx_sh <= RXSH_INIT;
      rx_perr <= 1'b0;
      brk_len <= 5'h00;
    end
    else
    begin
      if (tick)
        rx_cnt <= (rx_smp && rx_st != RX_START) ? 8'h00 : rx_cnt + 8'h01;
      case (rx_st)
        RX_IDLE:
        begin
          rx_cnt <= 8'h00;
          if (rx_prev && !rx_line)
            rx_st <= RX_START; // R24
        end
        RX_START:
          if (tick && rx_cnt == start_filter_count)
          begin
            rx_cnt <= 8'h00;
            rx_bits <= 4'h0;
            rx_sh <= RXSH_INIT; // R20
            rx_perr <= 1'b0;
            brk_len <= 5'h01;
            if (rx_line)
              rx_st <= RX_IDLE;
            else
              rx_st <= break_rx_pending ? RX_BRK : RX_DATA;
          end
        RX_DATA:
          if (rx_smp)
          begin
            if (ctrl.msb_first)
              rx_sh <= {rx_sh[7:0], rx_line}; // R14
            else
              rx_sh[rx_bits] <= rx_line;
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == nchar - 4'h1)
              rx_st <= par_on ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rx_smp)
          begin
            rx_perr <= (ctrl.parity == PAR_ZERO) ? rx_line : par_calc;
            rx_st <= RX_STOP;
          end
        RX_STOP:
          if (rx_smp)
            rx_st <= RX_IDLE; // second stop bit is not checked
        RX_BRK:
          if (rx_smp)
          begin
            if (rx_line)
              rx_st <= RX_IDLE;
            else if (brk_len != 5'h1F)
              brk_len <= brk_len + 5'h01;
          end
        default:
          rx_st <= RX_IDLE;
      endcase
    end
  end

  // activity flag and receive pulses share one edge
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !rx_on)
      rx_active_flag <= 1'b0; // R1
    else if (rx_conf)
      rx_active_flag <= 1'b1;
    else if (rx_end || brk_end)
      rx_active_flag <= 1'b0; // R2
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0;
    end
    else
    begin
      rx_done_irq <= rx_on & ((rx_end & ~rx_bad) | brk_ok); // R9 R11 R18
      rx_error_irq <= rx_on & rx_end & rx_bad; // R10 R11
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmitter, independent of the receiver
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !tx_on)
    begin
      tx_st <= TX_IDLE;
      tx_cnt <= 4'h0;
      tx_bits <= 5'h00;
      tx_sh <= 9'h000;
      tx_pbit <= 1'b0;
      tx_line <= 1'b1;
    end
    else
    begin
      if (tick)
        tx_cnt <= tx_cnt + 4'h1;
      case (tx_st)
        TX_IDLE:
        begin
          tx_cnt <= 4'h0;
          tx_bits <= 5'h00;
          if (brk_go)
          begin
            tx_line <= 1'b0; // R16
            tx_st <= TX_BRK;
          end
          else if (tx_load)
          begin
            tx_sh <= ctrl.msb_first ? rev_n(tx_data, nchar) : tx_data; // R14
            tx_pbit <= (ctrl.parity == PAR_ZERO) ? 1'b0
                       : (^tx_data ^ (ctrl.parity == PAR_ODD));
            tx_line <= 1'b0;
            tx_st <= TX_START;
          end
        end
        TX_START:
          if (tx_smp)
          begin
            tx_line <= tx_sh[0];
            tx_sh <= {1'b0, tx_sh[8:1]};
            tx_bits <= 5'h01;
            tx_st <= TX_DATA;
          end
        TX_DATA:
          if (tx_smp)
          begin
            if (tx_bits[3:0] == nchar)
            begin
              tx_line <= par_on ? tx_pbit : 1'b1; // R13
              tx_bits <= 5'h00;
              tx_st <= par_on ? TX_PAR : TX_STOP;
            end
            else
            begin
              tx_line <= tx_sh[0];
              tx_sh <= {1'b0, tx_sh[8:1]};
              tx_bits <= tx_bits + 5'h01;
            end
          end
        TX_PAR:
          if (tx_smp)
          begin
            tx_line <= 1'b1;
            tx_st <= TX_STOP;
          end
        TX_STOP:
          if (tx_smp)
          begin
            if (ctrl.stop2 && tx_bits == 5'h00)
              tx_bits <= 5'h01;
            else
              tx_st <= TX_IDLE;
          end
        TX_BRK:
          if (brk_done)
          begin
            tx_line <= 1'b1;
            tx_st <= TX_IDLE;
          end
          else if (tx_smp)
            tx_bits <= tx_bits + 5'h01;
        default:
          tx_st <= TX_IDLE;
      endcase
    end
  end

  // line driver and ready pulse
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      serial_out <= 1'b1;
      tx_ready_irq <= 1'b0;
    end
    else
    begin
      serial_out <= tx_line ^ tx_invert; // R14
      tx_ready_irq <= tx_load | brk_go; // R12 R17
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  a_rx_irq_excl: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    !(rx_done_irq && rx_error_irq)) else $error("done and error together");
  a_rx_active_clr: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    rx_done_irq |-> !rx_active_flag) else $error("active flag still set");
  a_rxbuf_pwr_off: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    !ctrl.unit_power |=> rx_buf == RXBUF_RST) else $error("rx buffer not 1FF");
  a_ovr_keep_buf: assert property (@(posedge mclk) disable iff (!rst_n) // R6
    (ev_ov && ctrl.unit_power) |=> $stable(rx_buf) && rx_error_irq)
    else $error("overrun frame loaded");
  a_rx_off_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // R9
    !rx_on |=> !rx_done_irq) else $error("done pulse while disabled");
  a_tx_load_irq: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    (tx_load || brk_go) |=> tx_ready_irq ##1 !tx_ready_irq) else $error("ready pulse wrong");
  a_brk_trig_clr: assert property (@(posedge mclk) disable iff (!rst_n) // R23
    brk_done |=> !break_tx_trigger && tx_st == TX_IDLE) else $error("trigger not cleared");
  a_brk_line_low: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    (tx_st == TX_BRK) |=> serial_out == tx_invert) else $error("break not low");
  a_ovr_set_cause: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    $rose(err_flags[STS_OVE]) |-> $past(ev_ov)) else $error("overrun set without cause");
  a_brk_short: assert property (@(posedge mclk) disable iff (!rst_n || !rx_on) // R19
    brk_shrt |=> !rx_done_irq && !rx_error_irq && break_rx_pending)
    else $error("short break mishandled");
endmodule
`default_nettype wire

// ===== ulbrt_node.sv
// ulbrt_node: remote node on the far side of the serial line.
// assumes 16 mclk cycles per bit, so the baud divisor is 1.
`timescale 1ns/1ns
`default_nettype none
module ulbrt_node #(
  parameter int BT = 16
)(
  input  wire logic mclk,
  input  wire logic tx_line,
  output var  logic rx_line
);
  // the bus has a pull-up, so a released line idles high
  initial rx_line = 1'b1;
  ////////////////////////////////////////////////////////////////////
  // drive n bit times, first bit first, then release to idle
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= v[i];
      repeat (BT) @(posedge mclk);
    end
    rx_line <= 1'b1;
  endtask
  // bounded wait for a falling edge; a silent line returns late, not never
  task automatic fall;
    int i;
    i = 0;
    while (tx_line !== 1'b0 && i < 2000)
    begin
      @(posedge mclk);
      i++;
    end
  endtask
  // sample mid-bit, start bit lands in bit 0
  task automatic grab(output logic [15:0] v, input int n);
    v = 16'h0000;
    fall;
    repeat (BT / 2) @(posedge mclk);
    for (int i = 0; i < n; i++)
    begin
      v[i] = tx_line;
      repeat (BT) @(posedge mclk);
    end
  endtask
  // length of one low period in cycles
  task automatic span(output int low);
    low = 0;
    fall;
    while (tx_line === 1'b0 && low < 2000)
    begin
      @(posedge mclk);
      low++;
    end
  endtask
endmodule
`default_nettype wire

// ===== uart_lin_break_rx_tx_test.sv
// uart_lin_break_rx_tx_test: register-level bench over AHB-Lite.
// assumes the baud divisor is cut to 1 so a bit lasts 16 cycles.
`timescale 1ns/1ns
`default_nettype none
module uart_lin_break_rx_tx_test;
  import ulbrt_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        serial_in;
  logic        serial_out;
  wire  [2:0]  irq;
  logic [31:0] rd;
  logic [15:0] bits;
  int          low;
  int          n_done = 0;
  int          n_err = 0;
  int          n_fail = 0;
  int          total_checks = 0;

  always #10 mclk = ~mclk;
  // one pulse per cycle at most, so counting edges counts events
  always @(posedge mclk)
  begin
    if (irq[0] === 1'b1) n_done++;
    if (irq[1] === 1'b1) n_err++;
  end

  ulbrt_core #(.BAUD_DIV_RST(16'h0001)) uut (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .serial_in(serial_in), .serial_out(serial_out),
    .rx_done_irq(irq[0]), .rx_error_irq(irq[1]), .tx_ready_irq(irq[2]));
  ulbrt_node lin (.mclk(mclk), .tx_line(serial_out), .rx_line(serial_in));
  ////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for an event; a lost event ends the run
  task automatic wait_ev(input int k, input int lim);
    int i;
    i = 0;
    while (irq[k] !== 1'b1 && i < lim)
    begin
      @(posedge mclk);
      i++;
    end
    if (i >= lim)
    begin
      n_fail++;
      final_report;
    end
  endtask
  // bounded wait for hready; a stuck slave ends the run
  task automatic rdy;
    int i;
    i = 0;
    while (hreadyout !== 1'b1 && i < 40)
    begin
      @(posedge mclk);
      i++;
    end
    if (i >= 40)
    begin
      n_fail++;
      final_report;
    end
  endtask
  // one single transfer: hold address phase, then data phase
  task automatic bus(input logic [29:0] idx, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {idx, 2'b00};
    @(posedge mclk);
    while (hreadyout !== 1'b1) rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) rdy;
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(IDX_RX, 1'b0, 32'h0); chk(rd, 32'h1FF);
    bus(IDX_TX, 1'b0, 32'h0); chk(rd, 32'h1FF);
    bus(IDX_RX, 1'b1, 32'h0);
    bus(IDX_RX, 1'b0, 32'h0); chk(rd, 32'h1FF);
    bus(30'h0FFFFA01, 1'b0, 32'h0); chk(rd, 32'h0);
    bus(IDX_OPT0, 1'b0, 32'h0); chk(rd & 32'h1C, 32'h14);
    $display("test registers done");
    bus(IDX_CTRL, 1'b1, 32'h0F);
    fork
      lin.grab(bits, 10);
      begin
        bus(IDX_TX, 1'b1, 32'h80);
        wait_ev(2, 40);
      end
    join
    chk({16'h0, bits}, 32'h300);
    fork
      lin.span(low);
      begin
        bus(IDX_OPT0, 1'b1, 32'h34);
        wait_ev(2, 40);
      end
    join
    chk(low, 13 * 16);
    bus(IDX_STS, 1'b0, 32'h0); chk(rd & 32'h80, 32'h0);
    $display("test transmit done");
    fork
      lin.send(16'h2AA, 10);
      wait_ev(0, 300);
    join
    // first frame left unread on purpose so the second overruns
    fork
      lin.send(16'h34A, 10);
      wait_ev(1, 300);
    join
    chk(n_done, 1);
    chk(n_err, 1);
    bus(IDX_STS, 1'b0, 32'h0); chk(rd & 32'h7, 32'h1);
    bus(IDX_STS, 1'b1, 32'h7);
    bus(IDX_STS, 1'b0, 32'h0); chk(rd & 32'h7, 32'h1);
    bus(IDX_STS, 1'b1, 32'h0);
    bus(IDX_STS, 1'b0, 32'h0); chk(rd & 32'h7, 32'h0);
    bus(IDX_RX, 1'b0, 32'h0); chk(rd, 32'h055);
    bus(IDX_CTRL, 1'b1, 32'h27);
    fork
      lin.send(16'h1AC, 9);
      wait_ev(0, 300);
      begin
        repeat (60) @(posedge mclk);
        bus(IDX_RXST, 1'b0, 32'h0);
        chk(rd, 32'h1);
      end
    join
    bus(IDX_RXST, 1'b0, 32'h0); chk(rd, 32'h0);
    bus(IDX_RX, 1'b0, 32'h0); chk(rd, 32'h06A);
    $display("test receive done");
    bus(IDX_OPT0, 1'b1, 32'h54);
    lin.send(16'h200, 10);
    repeat (64) @(posedge mclk);
    bus(IDX_OPT0, 1'b0, 32'h0); chk(rd & 32'h80, 32'h80);
    chk(n_done, 2);
    fork
      lin.send(16'h1000, 13);
      wait_ev(0, 400);
    join
    bus(IDX_OPT0, 1'b0, 32'h0); chk(rd & 32'h80, 32'h0);
    bus(IDX_RX, 1'b0, 32'h0); chk(rd, 32'h06A);
    chk(n_err, 1);
    $display("test break receive done");
    // 7-bit, MSB first, even parity on both directions
    bus(IDX_CTRL, 1'b1, 32'hE7);
    fork
      lin.grab(bits, 10);
      begin
        bus(IDX_TX, 1'b1, 32'h34);
        wait_ev(2, 40);
      end
    join
    chk({16'h0, bits}, 32'h32C);
    // same character with its parity bit flipped
    fork
      lin.send(16'h22C, 10);
      wait_ev(1, 300);
    join
    bus(IDX_STS, 1'b0, 32'h0); chk(rd & 32'h7, 32'h4);
    bus(IDX_RX, 1'b0, 32'h0); chk(rd, 32'h068);
    // power off refills the buffer; the extra edge lets the refill land
    bus(IDX_CTRL, 1'b1, 32'h0);
    @(posedge mclk);
    bus(IDX_RX, 1'b0, 32'h0); chk(rd, 32'h1FF);
    bus(IDX_OPT0, 1'b1, 32'h16);
    repeat (2) @(posedge mclk);
    chk({31'h0, serial_out}, 32'h0);
    $display("test options done");
    final_report;
  end
endmodule
`default_nettype wire
